// >>> hw/sd_pkg.sv
package sd_pkg;

  // Word offsets on the slave port (six-bit word address).
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_STATUS = 6'h01;
  localparam logic [5:0] OFS_CMD = 6'h02;
  localparam logic [5:0] OFS_DMA_ADDR = 6'h03;
  localparam logic [5:0] OFS_DMA_CTRL = 6'h04;
  localparam logic [5:0] OFS_TX = 6'h05;
  localparam logic [5:0] OFS_RESP = 6'h06;
  // The upper half of the word space is the data buffer window.
  localparam int BUF_WIN_BIT = 5;

  // Control register fields.
  localparam int CTRL_DIV_LSB = 0;
  localparam int CTRL_WIDE_BIT = 8;
  localparam int CTRL_RUN_BIT = 9;
  localparam int CTRL_IRQ_EN_BIT = 10;
  localparam logic [7:0] CTRL_DIV_RST = 8'hff;

  // Status register fields.
  localparam int ST_PRESENT_BIT = 0;
  localparam int ST_WPROT_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int ST_DONE_BIT = 3;
  localparam int ST_DAT_LSB = 4;

  // DMA control fields; the count sits in the low bits.
  localparam int DMA_DIR_BIT = 8;

  // Highest card clock rate in high-speed mode.
  localparam longint CARD_CLK_MAX_HZ = 64'd50_000_000;

  // Slave port request as seen on the pins.
  typedef struct packed {
    logic cs;
    logic [5:0] addr;
    logic rd_n;
    logic wr_n;
    logic [3:0] be_n;
    logic [31:0] wdata;
  } slave_req_t;

  // Master port request driven by the DMA engine.
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be_n;
    logic rd_n;
    logic wr_n;
  } master_req_t;

endpackage

// >>> hw/sd_word_mem.sv
`timescale 1ns/1ns
// Data buffer with one write port and one registered read port.
module sd_word_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wbe,
  input wire logic i_re,
  input wire logic [AW-1:0] i_raddr,
  output logic [31:0] o_rdata
);

  logic [31:0] mem [DEPTH];

  // The address width must cover the depth exactly.
  initial begin
    if (DEPTH != (1 << AW)) begin
      $error("sd_word_mem: DEPTH must equal 2**AW.");
    end
  end

  // Byte lanes are written one at a time so partial writes keep the rest.
  always_ff @(posedge i_core_clk) begin
    for (int b = 0; b < 4; b++) begin
      if (i_we && i_wbe[b]) begin
        mem[i_waddr][8*b +: 8] <= i_wdata[8*b +: 8];
      end
    end
    if (i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

// >>> hw/sd_skid_fifo.sv
`timescale 1ns/1ns
// Two-entry buffer; a stall downstream never drops an accepted word.
module sd_skid_fifo #(
  parameter int WIDTH = 32
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic [1:0] cnt;
  } fifo_t;

  fifo_t st;
  fifo_t next_st;

  initial begin
    if (WIDTH < 1) begin
      $error("sd_skid_fifo: WIDTH must be positive.");
    end
  end

  // Full at two entries, empty at none; both come from the count.
  assign o_in_ready = (st.cnt != 2'd2);
  assign o_out_valid = (st.cnt != 2'd0);
  assign o_out_data = st.slot[0];

  // Pop shifts slot one down; push lands behind whatever remains.
  always_comb begin
    logic push;
    logic pop;
    push = 1'b0;
    pop = 1'b0;
    next_st = st;
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    if (pop) begin
      next_st.slot[0] = st.slot[1];
    end
    if (push) begin
      next_st.slot[(pop ? st.cnt - 2'd1 : st.cnt) == 2'd0 ? 0 : 1] =
        i_in_data;
    end
    next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule

// >>> hw/sd_pin_front.sv
`timescale 1ns/1ns
// Operation
// R1 - Everything runs on the single system clock
// R2 - Card clock divided from system clock
// R3 - Software sets the divider at run time
// R4 - High-speed mode up to fifty megahertz
// R5 - Card clock flop launched by launch clock
// R6 - Data bus runs one-line or four-line
// R7 - Command line split into out, in, enable
// R8 - Data lines split into out, in, enable
// R9 - Card detect low means card inserted
// R10 - Write protect high means writes refused
// R11 - Active-low reset holds the reset state
// R12 - Slave port reaches registers and buffer
// R13 - DMA moves words through master port
// R14 - Interrupt output notifies the processor
// R15 - Host uses 32-bit data, strobes active low
// R16 - Hold master request while wait asserted
// R17 - Card bus undriven after reset
module sd_pin_front #(
  parameter longint CORE_HZ = 64'd25_000_000,
  parameter int BUF_DEPTH = 32
) (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire sd_pkg::slave_req_t i_slave,
  output logic [31:0] o_rdata,
  output sd_pkg::master_req_t o_master,
  input wire logic [31:0] i_m_rdata,
  input wire logic i_m_wait_n,
  output logic o_interrupt_request_out,
  output logic o_card_clock_out,
  input wire logic i_command_line_in,
  output logic o_command_line_out,
  output logic o_command_line_drive_enable,
  input wire logic [3:0] i_data_lines_in,
  output logic [3:0] o_data_lines_out,
  output logic [3:0] o_data_lines_drive_enable,
  input wire logic i_card_present_low,
  input wire logic i_write_protect,
  output logic o_activity_indicator
);
  import sd_pkg::*;

  localparam int AW = $clog2(BUF_DEPTH);
  // Fastest legal divider setting keeps the card clock under its limit.
  localparam longint DIV_MIN_L =
    (CORE_HZ + 2 * CARD_CLK_MAX_HZ - 1) / (2 * CARD_CLK_MAX_HZ) - 1; // [R4]
  localparam logic [7:0] DIV_MIN = 8'(DIV_MIN_L);

  initial begin
    if (BUF_DEPTH < 2 || BUF_DEPTH > 32) begin
      $error("sd_pin_front: BUF_DEPTH must be 2 to 32.");
    end
    if (DIV_MIN_L > 255) begin
      $error("sd_pin_front: core clock too fast for the divider.");
    end
  end

  typedef enum logic [1:0] {DMA_IDLE, DMA_RD, DMA_FETCH, DMA_WR} dma_t;

  // Whole state of the block, registered in one place.
  typedef struct packed {
    logic [7:0] div_ratio;
    logic wide;
    logic clk_run;
    logic irq_en;
    logic [7:0] div_cnt;
    logic card_clk;
    logic [7:0] cmd_sh;
    logic [3:0] cmd_cnt;
    logic cmd_oe;
    logic cmd_out;
    logic [31:0] dat_sh;
    logic [5:0] dat_cnt;
    logic [3:0] dat_oe;
    logic [3:0] dat_out;
    logic [31:0] resp;
    logic [3:0] dat_in;
    logic present;
    logic wprot;
    logic done;
    logic irq;
    logic [31:0] hold;
    logic rd_buf;
    logic rd_reg;
    logic [31:0] rdata;
    dma_t dma_st;
    logic [31:0] dma_addr;
    logic [5:0] dma_left;
    logic [AW-1:0] dma_idx;
    master_req_t m;
    logic [5:0] tx_left;
    logic [AW-1:0] tx_idx;
    logic tx_pend;
    logic activity_indicator;
  } state_t;

  state_t st;
  state_t next_st;

  // Buffer ports, driven from the combinational process below.
  logic mem_we;
  logic [AW-1:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [3:0] mem_wbe;
  logic mem_re;
  logic [AW-1:0] mem_raddr;
  logic [31:0] mem_rdata;
  // Transmit buffer handshake.
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [31:0] fifo_out_data;

  // Strobes decoded from the slave pins and from the divider count.
  logic s_rd;
  logic s_wr;
  logic [31:0] s_mask;
  logic rise_en;
  logic fall_en;

  assign s_rd = i_slave.cs && !i_slave.rd_n; // [R15]
  assign s_wr = i_slave.cs && !i_slave.wr_n; // [R15]

  // Active-low byte enables become a bit mask for register merges.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      s_mask[8*b +: 8] = {8{!i_slave.be_n[b]}};
    end
  end

  // Card clock edges are one-cycle enables of the core clock.
  assign rise_en = st.clk_run && (st.div_cnt == st.div_ratio) &&
    !st.card_clk; // [R2]
  assign fall_en = st.clk_run && (st.div_cnt == st.div_ratio) &&
    st.card_clk; // [R2]

  // The serializer takes a new word only on a falling card edge when idle.
  assign fifo_out_ready = fall_en && (st.dat_cnt == 6'd0);

  sd_word_mem #(.DEPTH(BUF_DEPTH), .AW(AW)) u_buf (
    .i_core_clk(i_core_clk),
    .i_we(mem_we),
    .i_waddr(mem_waddr),
    .i_wdata(mem_wdata),
    .i_wbe(mem_wbe),
    .i_re(mem_re),
    .i_raddr(mem_raddr),
    .o_rdata(mem_rdata)
  );

  sd_skid_fifo #(.WIDTH(32)) u_txq (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(st.tx_pend),
    .o_in_ready(fifo_in_ready),
    .i_in_data(mem_rdata),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_out_ready),
    .o_out_data(fifo_out_data)
  );

  // Next-state logic: slave port, divider, command, data, DMA, buffer.
  always_comb begin
    logic [31:0] wr_val;
    logic dma_ev;
    logic [31:0] dat_src;
    wr_val = '0;
    dma_ev = 1'b0;
    dat_src = '0;
    next_st = st;
    mem_we = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    mem_wbe = '0;
    mem_re = 1'b0;
    mem_raddr = '0;

    // Socket switches and data lines, sampled every cycle.
    next_st.present = !i_card_present_low; // [R9]
    next_st.wprot = i_write_protect; // [R10]
    next_st.dat_in = i_data_lines_in; // [R8]

    // Divider: the count wraps at the ratio and the clock toggles.
    if (!st.clk_run) begin
      next_st.div_cnt = '0;
    end else if (st.div_cnt == st.div_ratio) begin
      next_st.div_cnt = '0;
      next_st.card_clk = !st.card_clk; // [R2] [R5]
    end else begin
      next_st.div_cnt = st.div_cnt + 8'd1;
    end

    // Command line: shift out MSB first on falling card edges.
    if (fall_en) begin
      if (st.cmd_cnt != 4'd0) begin
        next_st.cmd_out = st.cmd_sh[7]; // [R7]
        next_st.cmd_sh = {st.cmd_sh[6:0], 1'b1};
        next_st.cmd_cnt = st.cmd_cnt - 4'd1;
        next_st.cmd_oe = 1'b1; // [R7]
      end else begin
        next_st.cmd_oe = 1'b0;
        next_st.cmd_out = 1'b1;
      end
    end
    // Responses are sampled on rising edges while the host is silent.
    if (rise_en && !st.cmd_oe) begin
      next_st.resp = {st.resp[30:0], i_command_line_in}; // [R7]
    end

    // Data lines: a word leaves as eight nibbles or thirty-two bits.
    // A fresh word puts out its first unit on the edge that takes it,
    // so words follow back to back and no unit is sent twice.
    if (fall_en) begin
      if (st.dat_cnt != 6'd0 || fifo_out_valid) begin
        dat_src = (st.dat_cnt != 6'd0) ? st.dat_sh : fifo_out_data;
        if (st.wide) begin
          next_st.dat_out = dat_src[31:28]; // [R6]
          next_st.dat_sh = {dat_src[27:0], 4'hf};
          next_st.dat_oe = 4'hf; // [R8]
        end else begin
          next_st.dat_out = {3'b111, dat_src[31]}; // [R6]
          next_st.dat_sh = {dat_src[30:0], 1'b1};
          next_st.dat_oe = 4'h1; // [R8]
        end
        if (st.dat_cnt != 6'd0) begin
          next_st.dat_cnt = st.dat_cnt - 6'd1;
        end else begin
          next_st.dat_cnt = st.wide ? 6'd7 : 6'd31;
        end
      end else begin
        next_st.dat_oe = 4'h0;
        next_st.dat_out = 4'hf;
      end
    end

    // Slave read: latency two, the buffer's read data pass a flop.
    next_st.rd_buf = 1'b0;
    next_st.rd_reg = 1'b0;
    if (s_rd) begin
      next_st.rd_buf = i_slave.addr[BUF_WIN_BIT]; // [R12]
      next_st.rd_reg = !i_slave.addr[BUF_WIN_BIT];
      unique case (i_slave.addr)
        OFS_CTRL: next_st.hold = {21'h0, st.irq_en, st.clk_run, st.wide,
          st.div_ratio};
        OFS_STATUS: next_st.hold = {24'h0, st.dat_in, st.done,
          (st.dma_st != DMA_IDLE) || (st.tx_left != 6'd0), st.wprot,
          st.present};
        OFS_CMD: next_st.hold = {24'h0, st.cmd_sh};
        OFS_DMA_ADDR: next_st.hold = st.dma_addr;
        OFS_DMA_CTRL: next_st.hold = {26'h0, st.dma_left};
        OFS_TX: next_st.hold = {26'h0, st.tx_left};
        OFS_RESP: next_st.hold = st.resp;
        default: next_st.hold = '0;
      endcase
    end
    if (st.rd_buf) begin
      next_st.rdata = mem_rdata;
    end else if (st.rd_reg) begin
      next_st.rdata = st.hold;
    end

    // Register writes honour byte enables, except DMA control and transmit count writes.
    if (s_wr && !i_slave.addr[BUF_WIN_BIT]) begin
      unique case (i_slave.addr)
        OFS_CTRL: begin
          wr_val = (i_slave.wdata & s_mask) | ({21'h0, st.irq_en,
            st.clk_run, st.wide, st.div_ratio} & ~s_mask);
          next_st.div_ratio = (wr_val[CTRL_DIV_LSB +: 8] < DIV_MIN) ?
            DIV_MIN : wr_val[CTRL_DIV_LSB +: 8]; // [R3] [R4]
          next_st.wide = wr_val[CTRL_WIDE_BIT]; // [R6]
          next_st.clk_run = wr_val[CTRL_RUN_BIT];
          next_st.irq_en = wr_val[CTRL_IRQ_EN_BIT];
        end
        OFS_STATUS: begin
          if (!i_slave.be_n[0] && i_slave.wdata[ST_DONE_BIT]) begin
            next_st.done = 1'b0;
          end
        end
        OFS_CMD: begin
          if (st.cmd_cnt == 4'd0 && !i_slave.be_n[0]) begin
            next_st.cmd_sh = i_slave.wdata[7:0];
            next_st.cmd_cnt = 4'd8;
          end
        end
        OFS_DMA_ADDR: begin
          next_st.dma_addr = (i_slave.wdata & s_mask) |
            (st.dma_addr & ~s_mask);
        end
        OFS_DMA_CTRL: begin
          if (st.dma_st == DMA_IDLE && i_slave.wdata[5:0] != 6'd0) begin
            next_st.dma_left = i_slave.wdata[5:0];
            next_st.dma_idx = '0;
            next_st.dma_st = i_slave.wdata[DMA_DIR_BIT] ? DMA_FETCH :
              DMA_RD; // [R13]
          end
        end
        OFS_TX: begin
          if (st.tx_left == 6'd0) begin
            next_st.tx_left = i_slave.wdata[5:0];
            next_st.tx_idx = '0;
          end
        end
        default: begin
        end
      endcase
    end

    // DMA engine owns the buffer write port; a slave buffer read takes the read port first.
    next_st.m.be_n = 4'h0;
    unique case (st.dma_st)
      DMA_IDLE: begin
        next_st.m.rd_n = 1'b1;
        next_st.m.wr_n = 1'b1;
      end
      DMA_RD: begin
        next_st.m.addr = st.dma_addr;
        next_st.m.rd_n = 1'b0; // [R13]
        if (!st.m.rd_n && i_m_wait_n) begin
          mem_we = 1'b1;
          mem_waddr = st.dma_idx;
          mem_wdata = i_m_rdata;
          mem_wbe = 4'hf;
          next_st.dma_idx = st.dma_idx + 1'b1;
          next_st.dma_addr = st.dma_addr + 32'd4;
          next_st.m.addr = st.dma_addr + 32'd4;
          next_st.dma_left = st.dma_left - 6'd1;
          if (st.dma_left == 6'd1) begin
            next_st.m.rd_n = 1'b1;
            next_st.dma_st = DMA_IDLE;
            dma_ev = 1'b1;
          end
        end else if (!st.m.rd_n) begin
          next_st.m = st.m; // [R16]
        end
      end
      DMA_FETCH: begin
        // A slave buffer read takes the port; the fetch tries again.
        mem_re = 1'b1;
        mem_raddr = st.dma_idx;
        if (!(s_rd && i_slave.addr[BUF_WIN_BIT])) begin
          next_st.dma_st = DMA_WR;
        end
      end
      DMA_WR: begin
        if (st.m.wr_n) begin
          next_st.m.addr = st.dma_addr;
          next_st.m.wdata = mem_rdata;
          next_st.m.wr_n = 1'b0; // [R13]
        end else if (i_m_wait_n) begin
          next_st.m.wr_n = 1'b1;
          next_st.dma_idx = st.dma_idx + 1'b1;
          next_st.dma_addr = st.dma_addr + 32'd4;
          next_st.dma_left = st.dma_left - 6'd1;
          if (st.dma_left == 6'd1) begin
            next_st.dma_st = DMA_IDLE;
            dma_ev = 1'b1;
          end else begin
            next_st.dma_st = DMA_FETCH;
          end
        end else begin
          next_st.m = st.m; // [R16]
        end
      end
    endcase

    // Slave buffer writes yield to a DMA write in the same cycle.
    if (s_wr && i_slave.addr[BUF_WIN_BIT] && !mem_we) begin
      mem_we = 1'b1; // [R12]
      mem_waddr = i_slave.addr[AW-1:0];
      mem_wdata = i_slave.wdata;
      mem_wbe = ~i_slave.be_n;
    end

    // One read port: slave, then DMA fetch, then the transmit feeder.
    next_st.tx_pend = 1'b0;
    if (s_rd && i_slave.addr[BUF_WIN_BIT]) begin
      mem_re = 1'b1;
      mem_raddr = i_slave.addr[AW-1:0];
    end else if (!mem_re && st.tx_left != 6'd0 && !st.tx_pend &&
        fifo_in_ready) begin
      // Only one word in flight, so a ready buffer still has room.
      mem_re = 1'b1;
      mem_raddr = st.tx_idx;
      next_st.tx_pend = 1'b1;
      next_st.tx_idx = st.tx_idx + 1'b1;
      next_st.tx_left = st.tx_left - 6'd1;
    end

    // Finished DMA sets the sticky flag; the set wins over a clear.
    if (dma_ev) begin
      next_st.done = 1'b1;
    end
    next_st.irq = next_st.done && next_st.irq_en; // [R14]
    next_st.activity_indicator = next_st.cmd_oe || (next_st.dat_oe != 4'h0) ||
      (next_st.dma_st != DMA_IDLE);
  end

  // Single clock and synchronous active-low reset for the whole state register.
  always_ff @(posedge i_core_clk) begin // [R1]
    if (!i_rst_n) begin // [R11]
      st <= '0; // [R17]
      st.div_ratio <= CTRL_DIV_RST;
      st.cmd_out <= 1'b1;
      st.dat_out <= 4'hf;
      st.cmd_sh <= 8'hff;
      st.m.rd_n <= 1'b1;
      st.m.wr_n <= 1'b1;
      st.m.be_n <= 4'hf;
      st.dma_st <= DMA_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a field of the state register.
  assign o_rdata = st.rdata;
  assign o_master = st.m;
  assign o_interrupt_request_out = st.irq;
  assign o_card_clock_out = st.card_clk; // [R5]
  assign o_command_line_out = st.cmd_out;
  assign o_command_line_drive_enable = st.cmd_oe;
  assign o_data_lines_out = st.dat_out;
  assign o_data_lines_drive_enable = st.dat_oe;
  assign o_activity_indicator = st.activity_indicator;

  property p_quiet_after_reset;
    @(posedge i_core_clk) !i_rst_n |=> !o_command_line_drive_enable &&
      o_data_lines_drive_enable == 4'h0;
  endproperty
  a_quiet_after_reset: assert property (p_quiet_after_reset) // [R17]
    else $error("Card bus driven right after reset.");

  property p_present;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_card_present_low ##1 s_rd && i_slave.addr == OFS_STATUS
      |-> ##2 o_rdata[ST_PRESENT_BIT] == 1'b0;
  endproperty
  a_present: assert property (p_present) // [R9]
    else $error("Empty socket reported as present.");

  property p_wprot;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      i_write_protect ##1 s_rd && i_slave.addr == OFS_STATUS
      |-> ##2 o_rdata[ST_WPROT_BIT] == 1'b1;
  endproperty
  a_wprot: assert property (p_wprot) // [R10]
    else $error("Write protect not reported.");

  property p_clk_period;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      $changed(o_card_clock_out) |-> $past(st.div_cnt) == $past(st.div_ratio);
  endproperty
  a_clk_period: assert property (p_clk_period) // [R2]
    else $error("Card clock toggled off the divider count.");

  property p_bus_width;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      o_data_lines_drive_enable != 4'h0 |->
      o_data_lines_drive_enable == (st.wide ? 4'hf : 4'h1);
  endproperty
  a_bus_width: assert property (p_bus_width) // [R6]
    else $error("Data drive enables do not match bus width.");

  property p_master_hold;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      (!o_master.rd_n || !o_master.wr_n) && !i_m_wait_n |=>
      $stable(o_master.addr) && $stable(o_master.rd_n) &&
      $stable(o_master.wr_n);
  endproperty
  a_master_hold: assert property (p_master_hold) // [R16]
    else $error("Master request changed during wait.");

  property p_irq;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      st.done && st.irq_en |-> o_interrupt_request_out;
  endproperty
  a_irq: assert property (p_irq) // [R14]
    else $error("Interrupt missing for pending event.");

  property p_cmd_len;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      $fell(o_command_line_drive_enable) |-> $past(st.cmd_cnt) == 4'd0;
  endproperty
  a_cmd_len: assert property (p_cmd_len) // [R7]
    else $error("Command drive ended with bits left.");

  property p_div_floor;
    @(posedge i_core_clk) disable iff (!i_rst_n)
      1'b1 |-> st.div_ratio >= DIV_MIN;
  endproperty
  a_div_floor: assert property (p_div_floor) // [R4]
    else $error("Divider below the high-speed limit.");

endmodule

// >>> testbench/sd_card_model.sv
`timescale 1ns/1ns
// Card side: pull-ups on every line, bits collected at rising card edges.
module sd_card_model (
  input wire logic i_cclk,
  input wire logic i_clr,
  input wire logic i_co,
  input wire logic i_ce,
  output logic o_ci,
  input wire logic [3:0] i_do,
  input wire logic [3:0] i_de,
  input wire logic i_busy,
  output logic [3:0] o_di,
  output logic [31:0] o_csr,
  output logic [31:0] o_dsr,
  output int o_ccnt,
  output int o_dcnt,
  output logic o_bad
);
  // A released line rises to its pull-up, never a stale value.
  assign o_ci = i_ce ? i_co : 1'b1;
  // A busy card pulls line 0 low while the host is not driving it.
  assign o_di = (i_de & i_do) | (~i_de & {3'h7, ~i_busy});
  // The card samples on rising edges, as the host launches on falling.
  always @(posedge i_cclk or posedge i_clr) begin
    if (i_clr) begin
      o_csr <= '0;
      o_dsr <= '0;
      o_ccnt <= 0;
      o_dcnt <= 0;
      o_bad <= 1'b0;
    end else begin
      if (i_ce) begin
        o_csr <= {o_csr[30:0], i_co};
        o_ccnt <= o_ccnt + 1;
      end
      if (i_de == 4'hf) begin
        o_dsr <= {o_dsr[27:0], i_do};
        o_dcnt <= o_dcnt + 4;
      end else if (i_de == 4'h1) begin
        o_dsr <= {o_dsr[30:0], i_do[0]};
        o_dcnt <= o_dcnt + 1;
      end else if (i_de != 4'h0) begin
        // A partial enable mask is neither bus width.
        o_bad <= 1'b1;
      end
    end
  end
endmodule

// >>> testbench/sd_pin_front_tb.sv
`timescale 1ns/1ns
module sd_pin_front_tb;
  import sd_pkg::*;
  localparam slave_req_t IDLE = '{1'b0, 6'h0, 1'b1, 1'b1, 4'hf, 32'h0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  slave_req_t slv = IDLE;
  master_req_t mst;
  logic [31:0] rdata, mrd, csr, dsr, mwa, mwd;
  logic irq, cclk, co, ce, ci, bad;
  logic [3:0] dout, den, din;
  logic cd = 1'b0;
  logic wp = 1'b0;
  logic busy = 1'b0;
  logic clr = 1'b1;
  logic wait_n = 1'b1;
  logic [1:0] sc = 2'h0;
  logic stl = 1'b0;
  logic [33:0] held;
  int ccnt, dcnt;
  int n_fail = 0;
  int num_checks = 0;

  // The clock runs at 25 MHz.
  always #20 clk = ~clk;

  sd_pin_front i_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_slave(slv),
    .o_rdata(rdata), .o_master(mst), .i_m_rdata(mrd), .i_m_wait_n(wait_n),
    .o_interrupt_request_out(irq), .o_card_clock_out(cclk),
    .i_command_line_in(ci), .o_command_line_out(co),
    .o_command_line_drive_enable(ce), .i_data_lines_in(din),
    .o_data_lines_out(dout), .o_data_lines_drive_enable(den),
    .i_card_present_low(cd), .i_write_protect(wp),
    .o_activity_indicator());

  sd_card_model i_card (.i_cclk(cclk), .i_clr(clr), .i_co(co), .i_ce(ce),
    .o_ci(ci), .i_do(dout), .i_de(den), .i_busy(busy), .o_di(din),
    .o_csr(csr), .o_dsr(dsr), .o_ccnt(ccnt), .o_dcnt(dcnt), .o_bad(bad));

  // Memory word pattern derived from its byte address.
  function automatic logic [31:0] mem(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction

  task automatic chk(input string w, input logic [33:0] e,
                     input logic [33:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // A released read bus shows the inverse word, so a late capture shows.
  assign mrd = mst.rd_n ? ~mem(mst.addr) : mem(mst.addr);
  // Stall two cycles in four; a stalled request must not move.
  always @(posedge clk) begin
    sc <= sc + 2'h1;
    wait_n <= sc[1];
    if (stl) chk("m_hold", held, {mst.rd_n, mst.wr_n, mst.addr});
    stl <= rst_n && !wait_n && !(mst.rd_n && mst.wr_n);
    held <= {mst.rd_n, mst.wr_n, mst.addr};
    // Words written by the master are kept for the write scenario.
    if (!mst.wr_n && wait_n) {mwa, mwd} <= {mst.addr, mst.wdata};
  end

  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    @(posedge clk);
    slv <= '{1'b1, a, 1'b1, 1'b0, be, d};
    @(posedge clk);
    slv <= IDLE;
  endtask

  // Read data appears two edges after the request is driven, and is read one edge later.
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    slv <= '{1'b1, a, 1'b0, 1'b1, 4'h0, 32'h0};
    @(posedge clk);
    slv <= IDLE;
    repeat (2) @(posedge clk);
    #1 d = rdata;
  endtask

  task automatic kick();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask

  // Byte enables sit high in reset and drop to all lanes once it lifts.
  task automatic t_reset(input logic [3:0] be);
    chk("en", 0, {ce, den});
    chk("idle", 5'h1f, {co, dout});
    chk("m_idle", {2'h3, be}, {mst.rd_n, mst.wr_n, mst.be_n});
    chk("clk_irq", 0, {cclk, irq});
  endtask

  task automatic t_status();
    logic [31:0] d;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      cd <= k[0];
      wp <= k[1];
      busy <= k[1];
      repeat (3) @(posedge clk);
      rd(OFS_STATUS, d);
      chk("present", !k[0], d[ST_PRESENT_BIT]);
      chk("wprot", k[1], d[ST_WPROT_BIT]);
      chk("lines", {3'h7, !k[1]}, d[ST_DAT_LSB +: 4]);
    end
    @(posedge clk);
    {cd, wp, busy} <= 3'h0;
  endtask

  task automatic t_buf();
    logic [31:0] d;
    wr(6'h20, 32'h11223344, 4'h0);
    wr(6'h3f, 32'haabbccdd, 4'h0);
    wr(6'h20, 32'h55667788, 4'hc);
    rd(6'h20, d);
    chk("buf_lanes", 32'h11227788, d);
    rd(6'h3f, d);
    chk("buf_top", 32'haabbccdd, d);
    rd(6'h07, d);
    chk("unmapped", 0, d);
  endtask

  // Period is taken between the second and third rise, past the change.
  task automatic t_clk();
    int first, per, n, r;
    logic prev;
    for (int dv = 0; dv < 4; dv = dv * 2 + 1) begin
      wr(OFS_CTRL, 32'h200 | dv, 4'h0);
      r = 0;
      per = 0;
      prev = 1'b1;
      for (n = 0; n < 100 && per == 0; n++) begin
        @(posedge clk);
        #1;
        if (cclk && !prev) begin
          r++;
          if (r == 2) first = n;
          if (r == 3) per = n - first;
        end
        prev = cclk;
      end
      chk("period", 2 * (dv + 1), per);
    end
    wr(OFS_CTRL, 32'h1, 4'h0);
    repeat (2) @(posedge clk);
    // A stopped card clock holds its level, so any change counts.
    #1 prev = cclk;
    r = 0;
    repeat (20) begin
      @(posedge clk);
      #1 r += (cclk != prev);
    end
    chk("stopped", 0, r);
  endtask

  task automatic t_cmd();
    int n;
    wr(OFS_CTRL, 32'h201, 4'h0);
    kick();
    wr(OFS_CMD, 32'ha5, 4'h0);
    for (n = 0; n < 300 && (ccnt < 8 || ce); n++) @(posedge clk);
    chk("cmd_byte", 8'ha5, csr[7:0]);
    chk("cmd_bits", 8, ccnt);
    chk("cmd_idle", 1, co);
  endtask

  task automatic t_dma();
    logic [31:0] d;
    int n;
    wr(OFS_CTRL, 32'h601, 4'h0);
    wr(OFS_DMA_ADDR, 32'h100, 4'h0);
    wr(OFS_DMA_CTRL, 32'h2, 4'h0);
    d = 0;
    for (n = 0; n < 40 && !d[ST_DONE_BIT]; n++) rd(OFS_STATUS, d);
    chk("done", 1, d[ST_DONE_BIT]);
    chk("irq", 1, irq);
    rd(6'h20, d);
    chk("dma_w0", mem(32'h100), d);
    rd(6'h21, d);
    chk("dma_w1", mem(32'h104), d);
    wr(OFS_STATUS, 32'h8, 4'h0);
    repeat (2) @(posedge clk);
    #1 chk("irq_clr", 0, irq);
    // Buffer word 0 goes back out to a fresh memory address.
    wr(OFS_DMA_ADDR, 32'h200, 4'h0);
    wr(OFS_DMA_CTRL, 32'h101, 4'h0);
    repeat (12) @(posedge clk);
    chk("dma_wa", 32'h200, mwa);
    chk("dma_wd", mem(32'h100), mwd);
  endtask

  task automatic t_tx(input logic wide);
    int n;
    wr(OFS_CTRL, {wide, 8'h01} | 32'h200, 4'h0);
    kick();
    wr(OFS_TX, 32'h1, 4'h0);
    for (n = 0; n < 600 && (dcnt < 32 || den != 0); n++) @(posedge clk);
    chk("tx_word", mem(32'h100), dsr);
    chk("tx_bits", 32, dcnt);
    chk("tx_mask", 0, bad);
  endtask

  // A hang ends the run as a failure.
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    #1 t_reset(4'hf);
    @(posedge clk);
    rst_n <= 1'b1;
    clr <= 1'b0;
    repeat (2) @(posedge clk);
    #1 t_reset(4'h0);
    t_status();
    t_buf();
    t_clk();
    t_cmd();
    t_dma();
    t_tx(1'b1);
    t_tx(1'b0);
    end_of_test();
  end
endmodule
